// ==== rtl/gp_defines.vh ====
/*
 * Constants for the general purpose port block of ports 1 to 3:
 * special-function register addresses, reset values and widths.
 * Assumes the includer uses 8-bit register addresses and data.
 */
`ifndef GP_DEFINES_VH
`define GP_DEFINES_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define GP_PORT1_DATA 8'h90
`define GP_PORT2_DATA 8'ha0
`define GP_PORT3_DATA 8'hb0
`define GP_PORT1_OUTPUT_TYPE 8'ha5
`define GP_PORT2_OUTPUT_TYPE 8'ha6
`define GP_PORT2_COMPARE_VALUE 8'hb1
`define GP_PORT2_COMPARE_ENABLE 8'hb2
`define GP_PORT1_CROSSBAR_BYPASS 8'hd5
`define GP_PORT2_CROSSBAR_BYPASS 8'hd6
`define GP_PORT1_COMPARE_VALUE 8'he1
`define GP_PORT1_COMPARE_ENABLE 8'he2
`define GP_PORT1_ANALOG_SELECT 8'hf2
`define GP_PORT2_ANALOG_SELECT 8'hf3

// ----------------------------------------------------------------
// Bit-address decode of the bit-addressable data registers
// ----------------------------------------------------------------
`define GP_BIT_BASE_MASK 8'hf8
`define GP_BIT_INDEX_LSB 0
`define GP_BIT_INDEX_MSB 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define GP_RST_DATA 8'hff
`define GP_RST_OUTPUT_TYPE 8'h00
`define GP_RST_COMPARE_VALUE 8'hff
`define GP_RST_COMPARE_ENABLE 8'h00
`define GP_RST_CROSSBAR_BYPASS 8'h00
`define GP_RST_ANALOG_SELECT 8'hff

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define GP_PORT_WIDTH 8
`define GP_PORT_COUNT 3

`endif

// ==== rtl/gp_port_io.v ====
/*
 * General purpose I/O for ports 1, 2 and 3: data latches, analog or
 * digital input selection, open-drain or push-pull selection, crossbar
 * skip selection and a masked pin-match comparator on ports 1 and 2.
 * Assumes a special-function register port from the core (byte access,
 * bit write, read-modify-write flag), pins arriving asynchronously, and
 * an outside crossbar that routes drive and enable to the pad cells.
 * Port 3 input and output modes come from outside this block.
 */
`timescale 1ns/10ps
`default_nettype none
`include "gp_defines.vh"

module gp_port_io #(
  parameter PW = `GP_PORT_WIDTH
) (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Special-function register port
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  input wire sfr_rd,
  input wire sfr_rmw,
  input wire sfr_bit_wr,
  input wire sfr_bit_val,
  output reg [7:0] sfr_rdata_q,
  output reg sfr_hit_q,
  // Port 3 modes held outside this block
  input wire [PW-1:0] port3_analog_select,
  input wire [PW-1:0] port3_output_type,
  // Global controls
  input wire weak_pullup_disable,
  input wire match_interrupt_enable,
  // Pins, port 1 in the low byte
  input wire [3*PW-1:0] pin_in,
  // Toward the crossbar and pad cells
  output reg [3*PW-1:0] gpio_out_q,
  output reg [3*PW-1:0] gpio_oe_q,
  output reg [3*PW-1:0] pullup_en_q,
  output reg [3*PW-1:0] digital_en_q,
  output reg [2*PW-1:0] crossbar_skip_q,
  // Match event outputs
  output reg port_match_q,
  output reg match_irq_q,
  output reg oscillator_wake_q
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg [PW-1:0] p1_data_q;
  reg [PW-1:0] p2_data_q;
  reg [PW-1:0] p3_data_q;
  reg [PW-1:0] p1_otype_q;
  reg [PW-1:0] p2_otype_q;
  reg [PW-1:0] p1_bypass_q;
  reg [PW-1:0] p2_bypass_q;
  reg [PW-1:0] p1_cmp_val_q;
  reg [PW-1:0] p2_cmp_val_q;
  reg [PW-1:0] p1_cmp_en_q;
  reg [PW-1:0] p2_cmp_en_q;
  reg [PW-1:0] p1_analog_q;
  reg [PW-1:0] p2_analog_q;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  reg [3*PW-1:0] pin_meta_q;
  reg [3*PW-1:0] pin_sync_q;

  // Only pin_sync_q is read; the first stage may be metastable
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta_q <= {3*PW{1'b0}};
      pin_sync_q <= {3*PW{1'b0}};
    end else begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  wire [PW-1:0] p1_pins = pin_sync_q[PW-1:0];
  wire [PW-1:0] p2_pins = pin_sync_q[2*PW-1:PW];
  wire [PW-1:0] p3_pins = pin_sync_q[3*PW-1:2*PW];

  // ----------------------------------------------------------------
  // Bit write decode
  // ----------------------------------------------------------------
  // Bit addresses of a data register are its byte address plus index
  wire [7:0] bit_base = sfr_addr & `GP_BIT_BASE_MASK;
  wire [2:0] bit_idx = sfr_addr[`GP_BIT_INDEX_MSB:`GP_BIT_INDEX_LSB];
  wire [PW-1:0] bit_onehot = {{(PW-1){1'b0}}, 1'b1} << bit_idx;

  // Bit set and clear modify the latch, never the pin levels
  function [PW-1:0] bit_merge;
    input [PW-1:0] latch;
    input [PW-1:0] sel;
    input val;
    begin
      bit_merge = val ? (latch | sel) : (latch & ~sel);
    end
  endfunction

  // ----------------------------------------------------------------
  // Data latches
  // ----------------------------------------------------------------
  // No page input: the data latches answer whatever page the core is on
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      p1_data_q <= `GP_RST_DATA;
      p2_data_q <= `GP_RST_DATA;
      p3_data_q <= `GP_RST_DATA;
    end else if (sfr_bit_wr) begin
      if (bit_base == `GP_PORT1_DATA) begin
        p1_data_q <= bit_merge(p1_data_q, bit_onehot, sfr_bit_val);
      end
      if (bit_base == `GP_PORT2_DATA) begin
        p2_data_q <= bit_merge(p2_data_q, bit_onehot, sfr_bit_val);
      end
      if (bit_base == `GP_PORT3_DATA) begin
        p3_data_q <= bit_merge(p3_data_q, bit_onehot, sfr_bit_val);
      end
    end else if (sfr_wr) begin
      case (sfr_addr)
        `GP_PORT1_DATA: begin
          p1_data_q <= sfr_wdata;
        end
        `GP_PORT2_DATA: begin
          p2_data_q <= sfr_wdata;
        end
        `GP_PORT3_DATA: begin
          p3_data_q <= sfr_wdata;
        end
        default: begin
          p1_data_q <= p1_data_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      p1_otype_q <= `GP_RST_OUTPUT_TYPE;
      p2_otype_q <= `GP_RST_OUTPUT_TYPE;
      p1_bypass_q <= `GP_RST_CROSSBAR_BYPASS;
      p2_bypass_q <= `GP_RST_CROSSBAR_BYPASS;
      p1_cmp_val_q <= `GP_RST_COMPARE_VALUE;
      p2_cmp_val_q <= `GP_RST_COMPARE_VALUE;
      p1_cmp_en_q <= `GP_RST_COMPARE_ENABLE;
      p2_cmp_en_q <= `GP_RST_COMPARE_ENABLE;
      p1_analog_q <= `GP_RST_ANALOG_SELECT;
      p2_analog_q <= `GP_RST_ANALOG_SELECT;
    end else if (sfr_wr && !sfr_bit_wr) begin
      case (sfr_addr)
        `GP_PORT1_OUTPUT_TYPE: begin
          p1_otype_q <= sfr_wdata;
        end
        `GP_PORT2_OUTPUT_TYPE: begin
          p2_otype_q <= sfr_wdata;
        end
        `GP_PORT1_CROSSBAR_BYPASS: begin
          p1_bypass_q <= sfr_wdata;
        end
        `GP_PORT2_CROSSBAR_BYPASS: begin
          p2_bypass_q <= sfr_wdata;
        end
        `GP_PORT1_COMPARE_VALUE: begin
          p1_cmp_val_q <= sfr_wdata;
        end
        `GP_PORT2_COMPARE_VALUE: begin
          p2_cmp_val_q <= sfr_wdata;
        end
        `GP_PORT1_COMPARE_ENABLE: begin
          p1_cmp_en_q <= sfr_wdata;
        end
        `GP_PORT2_COMPARE_ENABLE: begin
          p2_cmp_en_q <= sfr_wdata;
        end
        `GP_PORT1_ANALOG_SELECT: begin
          p1_analog_q <= sfr_wdata;
        end
        `GP_PORT2_ANALOG_SELECT: begin
          p2_analog_q <= sfr_wdata;
        end
        default: begin
          p1_otype_q <= p1_otype_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Analog pins read 0 because their receiver is disabled
  wire [PW-1:0] p1_rd_pins = p1_pins & p1_analog_q;
  wire [PW-1:0] p2_rd_pins = p2_pins & p2_analog_q;
  wire [PW-1:0] p3_rd_pins = p3_pins & port3_analog_select;

  reg [7:0] rdata_d;
  reg hit_d;

  always @* begin
    rdata_d = 8'h00;
    hit_d = 1'b1;
    case (sfr_addr)
      `GP_PORT1_DATA: begin
        rdata_d = sfr_rmw ? p1_data_q : p1_rd_pins;
      end
      `GP_PORT2_DATA: begin
        rdata_d = sfr_rmw ? p2_data_q : p2_rd_pins;
      end
      `GP_PORT3_DATA: begin
        rdata_d = sfr_rmw ? p3_data_q : p3_rd_pins;
      end
      `GP_PORT1_OUTPUT_TYPE: begin
        rdata_d = p1_otype_q;
      end
      `GP_PORT2_OUTPUT_TYPE: begin
        rdata_d = p2_otype_q;
      end
      `GP_PORT1_CROSSBAR_BYPASS: begin
        rdata_d = p1_bypass_q;
      end
      `GP_PORT2_CROSSBAR_BYPASS: begin
        rdata_d = p2_bypass_q;
      end
      `GP_PORT1_COMPARE_VALUE: begin
        rdata_d = p1_cmp_val_q;
      end
      `GP_PORT2_COMPARE_VALUE: begin
        rdata_d = p2_cmp_val_q;
      end
      `GP_PORT1_COMPARE_ENABLE: begin
        rdata_d = p1_cmp_en_q;
      end
      `GP_PORT2_COMPARE_ENABLE: begin
        rdata_d = p2_cmp_en_q;
      end
      `GP_PORT1_ANALOG_SELECT: begin
        rdata_d = p1_analog_q;
      end
      `GP_PORT2_ANALOG_SELECT: begin
        rdata_d = p2_analog_q;
      end
      default: begin
        hit_d = 1'b0;
      end
    endcase
  end

  // Read data is held until the next read strobe
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sfr_rdata_q <= 8'h00;
      sfr_hit_q <= 1'b0;
    end else if (sfr_rd) begin
      sfr_rdata_q <= rdata_d;
      sfr_hit_q <= hit_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  wire [3*PW-1:0] all_latch = {p3_data_q, p2_data_q, p1_data_q};
  wire [3*PW-1:0] all_digital = {port3_analog_select, p2_analog_q, p1_analog_q};
  wire [3*PW-1:0] all_otype = {port3_output_type, p2_otype_q, p1_otype_q};
  reg [3*PW-1:0] drv_out_d;
  reg [3*PW-1:0] drv_oe_d;
  reg [3*PW-1:0] pull_d;

  genvar gi;
  generate
    for (gi = 0; gi < 3*PW; gi = gi + 1) begin : g_pin
      // Output type only counts on a digital pin
      always @* begin
        drv_out_d[gi] = all_latch[gi];
        if (!all_digital[gi]) begin
          drv_oe_d[gi] = 1'b0;
        end else if (all_latch[gi]) begin
          drv_oe_d[gi] = all_otype[gi];
        end else begin
          drv_oe_d[gi] = 1'b1;
        end
        pull_d[gi] = all_digital[gi] & ~weak_pullup_disable;
      end
    end
  endgenerate

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gpio_out_q <= {3*PW{1'b1}};
      gpio_oe_q <= {3*PW{1'b0}};
      pullup_en_q <= {3*PW{1'b0}};
      digital_en_q <= {3*PW{1'b1}};
      crossbar_skip_q <= {2*PW{1'b0}};
    end else begin
      gpio_out_q <= drv_out_d;
      gpio_oe_q <= drv_oe_d;
      pullup_en_q <= pull_d;
      digital_en_q <= all_digital;
      crossbar_skip_q <= {p2_bypass_q, p1_bypass_q};
    end
  end

  // ----------------------------------------------------------------
  // Port match
  // ----------------------------------------------------------------
  // Compares synchronised levels, so a glitch shorter than a clock is missed
  wire p1_mismatch = (p1_pins & p1_cmp_en_q) != (p1_cmp_val_q & p1_cmp_en_q);
  wire p2_mismatch = (p2_pins & p2_cmp_en_q) != (p2_cmp_val_q & p2_cmp_en_q);
  wire match_d = p1_mismatch | p2_mismatch;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      port_match_q <= 1'b0;
      match_irq_q <= 1'b0;
      oscillator_wake_q <= 1'b0;
    end else begin
      port_match_q <= match_d;
      match_irq_q <= match_d & match_interrupt_enable;
      oscillator_wake_q <= match_d;
    end
  end

endmodule // gp_port_io

`default_nettype wire

// ==== test/gp_port_io_sva.sv ====
/* Assertion checker for gp_port_io, attached to every instance by bind.
   Assumes one clock, asynchronous active-low reset, defines header. */
`timescale 1ns/10ps
`default_nettype none
`include "gp_defines.vh"
module gp_port_io_sva #(
  parameter PW = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic sfr_rmw,
  input wire logic sfr_bit_wr,
  input wire logic sfr_bit_val,
  input wire logic [7:0] sfr_rdata_q,
  // Controls and pins
  input wire logic [PW-1:0] port3_analog_select,
  input wire logic [PW-1:0] port3_output_type,
  input wire logic weak_pullup_disable,
  input wire logic match_interrupt_enable,
  input wire logic [3*PW-1:0] pin_in,
  // Pad side and events
  input wire logic [3*PW-1:0] gpio_out_q,
  input wire logic [3*PW-1:0] gpio_oe_q,
  input wire logic [3*PW-1:0] pullup_en_q,
  input wire logic [3*PW-1:0] digital_en_q,
  input wire logic port_match_q,
  input wire logic match_irq_q,
  input wire logic oscillator_wake_q
);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  analog_off_a: assert property (((gpio_oe_q | pullup_en_q) & ~digital_en_q) == 0)
    else $error("analog pin driven or pulled up");
  pullup_off_a: assert property (weak_pullup_disable [*2] |-> pullup_en_q == 0)
    else $error("pullup on while disabled");
  byte_write_a: assert property (
    sfr_wr && !sfr_bit_wr && sfr_addr == `GP_PORT1_DATA ##1 !sfr_wr && !sfr_bit_wr
    |-> ##1 ((gpio_out_q[7:0] ^ $past(sfr_wdata, 2)) & gpio_oe_q[7:0]) == 0)
    else $error("port 1 drive differs from written byte");
  od_high_a: assert property (
    (gpio_oe_q[3*PW-1:2*PW] & gpio_out_q[3*PW-1:2*PW] & ~$past(port3_output_type)) == 0)
    else $error("open-drain pin driven high");
  analog_read_a: assert property (
    sfr_rd && !sfr_rmw && sfr_addr == `GP_PORT3_DATA
    |=> (sfr_rdata_q & ~$past(port3_analog_select)) == 0)
    else $error("analog pin read as one");
  irq_gate_a: assert property (match_irq_q == (port_match_q && $past(match_interrupt_enable)))
    else $error("match request not gated by enable");
  wake_follow_a: assert property (oscillator_wake_q == port_match_q)
    else $error("wake differs from match event");
  sync_hold_a: assert property (
    ($stable(pin_in) && !sfr_wr && !sfr_bit_wr) [*4] |-> $stable(port_match_q))
    else $error("match event moved with quiet inputs");
  bit_write_a: assert property (
    sfr_bit_wr && !sfr_bit_val && (sfr_addr & 8'hf8) == `GP_PORT1_DATA
    ##1 !sfr_wr && !sfr_bit_wr |-> ##1 !gpio_out_q[$past(sfr_addr[2:0], 2)])
    else $error("bit write did not clear drive");
endmodule // gp_port_io_sva

bind gp_port_io gp_port_io_sva #(.PW(PW)) u_sva (.clk, .resetn, .sfr_addr, .sfr_wr,
  .sfr_wdata, .sfr_rd, .sfr_rmw, .sfr_bit_wr, .sfr_bit_val, .sfr_rdata_q,
  .port3_analog_select, .port3_output_type, .weak_pullup_disable,
  .match_interrupt_enable, .pin_in, .gpio_out_q, .gpio_oe_q, .pullup_en_q,
  .digital_en_q, .port_match_q, .match_irq_q, .oscillator_wake_q);
`default_nettype wire

// ==== test/gp_pin_model.sv ====
/* Model of the board side of the 24 pins behind the crossbar.
   Assumes the testbench decides which pins it drives from outside. */
`timescale 1ns/10ps
`default_nettype none
module gp_pin_model (
  // Clock
  input wire logic clk,
  // Pad side of the block
  input wire logic [23:0] gpio_out_q,
  input wire logic [23:0] gpio_oe_q,
  input wire logic [23:0] pullup_en_q,
  // Outside drivers
  input wire logic [23:0] ext_en,
  input wire logic [23:0] ext_val,
  output logic [23:0] pin_in
);
  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  logic [23:0] float_q = 24'h000000;
  // Undriven, unpulled pins wander so a stale level never passes
  always @(posedge clk) float_q <= ~float_q;
  assign pin_in = (gpio_oe_q & gpio_out_q) | (~gpio_oe_q & ext_en & ext_val)
    | (~gpio_oe_q & ~ext_en & (pullup_en_q | float_q));
endmodule // gp_pin_model
`default_nettype wire

// ==== test/tb_gp_port_io.sv ====
/* Self-checking testbench for gp_port_io with a board pin model.
   Assumes the checker is bound in from its own file. */
`timescale 1ns/10ps
`default_nettype none
module tb_gp_port_io;
  logic clk = 1'b0, resetn = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_rmw = 1'b0;
  logic sfr_bit_wr = 1'b0, sfr_bit_val = 1'b0, weak_pullup_disable = 1'b0;
  logic match_interrupt_enable = 1'b0, sfr_hit_q, port_match_q, match_irq_q;
  logic oscillator_wake_q;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata_q, d;
  logic [7:0] port3_analog_select = 8'hff, port3_output_type = 8'h00;
  logic [23:0] ext_en = 24'h000000, ext_val = 24'h000000, pin_in;
  logic [23:0] gpio_out_q, gpio_oe_q, pullup_en_q, digital_en_q;
  logic [15:0] crossbar_skip_q;
  int errors = 0, checked = 0, cycles = 0;
  always #25 clk = ~clk;
  gp_port_io #(.PW(8)) u_dut (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw),
    .sfr_bit_wr(sfr_bit_wr), .sfr_bit_val(sfr_bit_val), .sfr_rdata_q(sfr_rdata_q),
    .sfr_hit_q(sfr_hit_q), .port3_analog_select(port3_analog_select),
    .port3_output_type(port3_output_type), .weak_pullup_disable(weak_pullup_disable),
    .match_interrupt_enable(match_interrupt_enable), .pin_in(pin_in),
    .gpio_out_q(gpio_out_q), .gpio_oe_q(gpio_oe_q), .pullup_en_q(pullup_en_q),
    .digital_en_q(digital_en_q), .crossbar_skip_q(crossbar_skip_q),
    .port_match_q(port_match_q), .match_irq_q(match_irq_q),
    .oscillator_wake_q(oscillator_wake_q));
  gp_pin_model u_pins (.clk(clk), .gpio_out_q(gpio_out_q), .gpio_oe_q(gpio_oe_q),
    .pullup_en_q(pullup_en_q), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Byte write, or bit write when b is set
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic b);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_bit_val = v[0];
    sfr_wr = !b;
    sfr_bit_wr = b;
    @(negedge clk);
    sfr_wr = 1'b0;
    sfr_bit_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic m, output logic [7:0] q);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    sfr_rmw = m;
    @(negedge clk);
    sfr_rd = 1'b0;
    sfr_rmw = 1'b0;
    q = sfr_rdata_q;
  endtask
  task automatic finish_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] a[14] = '{8'h90, 8'ha0, 8'hb0, 8'ha5, 8'ha6, 8'hb1, 8'hb2, 8'hd5,
      8'hd6, 8'he1, 8'he2, 8'hf2, 8'hf3, 8'h00};
    logic [7:0] v[14] = '{8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00,
      8'h00, 8'hff, 8'h00, 8'hff, 8'hff, 8'h00};
    for (int i = 0; i < 14; i++) begin
      rd(a[i], 1'b0, d);
      chk("reset read", d, v[i]);
      chk("hit", sfr_hit_q, a[i] != 8'h00);
    end
    chk("oe", gpio_oe_q, 24'h000000);
    chk("digital", digital_en_q, 24'hffffff);
    chk("skip", crossbar_skip_q, 16'h0000);
  endtask
  task automatic t_drive;
    wr(8'ha5, 8'h0f, 1'b0);
    wr(8'h90, 8'h5a, 1'b0);
    @(negedge clk);
    chk("out", gpio_out_q[7:0], 8'h5a);
    chk("oe", gpio_oe_q[7:0], 8'haf);
    ext_en[6] = 1'b1;
    repeat (3) @(negedge clk);
    rd(8'h90, 1'b0, d);
    chk("pin read", d, 8'h1a);
    rd(8'h90, 1'b1, d);
    chk("latch read", d, 8'h5a);
  endtask
  task automatic t_analog;
    wr(8'hf2, 8'hf0, 1'b0);
    wr(8'hd5, 8'h0f, 1'b0);
    wr(8'hd6, 8'h42, 1'b0);
    port3_analog_select = 8'h0f;
    @(negedge clk);
    chk("digital", digital_en_q[7:0], 8'hf0);
    chk("pullup", pullup_en_q[7:0], 8'hf0);
    chk("oe", gpio_oe_q[7:0], 8'ha0);
    chk("skip", crossbar_skip_q, 16'h420f);
    rd(8'h90, 1'b0, d);
    chk("analog read", d, 8'h10);
    rd(8'hb0, 1'b0, d);
    chk("p3 read", d, 8'h0f);
    weak_pullup_disable = 1'b1;
    repeat (3) @(negedge clk);
    weak_pullup_disable = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic t_match;
    wr(8'hb2, 8'h01, 1'b0);
    repeat (3) @(negedge clk);
    chk("match", port_match_q, 1'b0);
    ext_en[8] = 1'b1;
    repeat (4) @(negedge clk);
    chk("match", port_match_q, 1'b1);
    chk("irq", match_irq_q, 1'b0);
    chk("wake", oscillator_wake_q, 1'b1);
    match_interrupt_enable = 1'b1;
    repeat (2) @(negedge clk);
    chk("irq", match_irq_q, 1'b1);
    ext_en[9:8] = 2'b10;
    repeat (4) @(negedge clk);
    chk("masked", port_match_q, 1'b0);
    wr(8'he2, 8'h80, 1'b0);
    wr(8'he1, 8'h00, 1'b0);
    @(negedge clk);
    chk("p1 equal", port_match_q, 1'b0);
    wr(8'he1, 8'h80, 1'b0);
    @(negedge clk);
    chk("p1 differ", port_match_q, 1'b1);
    wr(8'he2, 8'h00, 1'b0);
    wr(8'hb2, 8'h00, 1'b0);
  endtask
  task automatic t_bit;
    wr(8'h96, 8'h00, 1'b1);
    wr(8'hb2, 8'h5e, 1'b1);
    @(negedge clk);
    rd(8'h90, 1'b1, d);
    chk("bit latch", d, 8'h1a);
    chk("p1 oe", gpio_oe_q[7:0], 8'he0);
    chk("p3 oe", gpio_oe_q[23:16], 8'h04);
    rd(8'hb2, 1'b0, d);
    chk("mask kept", d, 8'h00);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      finish_test;
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    t_reset;
    t_drive;
    t_analog;
    t_match;
    t_bit;
    finish_test;
  end
endmodule // tb_gp_port_io
`default_nettype wire
